// [ctss_sequencer.sv]
// Processor time state sequencer with its register bus, active registers and memory handshake.
// What this block does
// - Twelve one-bit adder stages form the arithmetic unit.
// - Without carry in: 0+0 gives 0, one input gives 1, both give 0 with carry.
// - With carry in: one input gives 0 carry 1, both give 1 carry 1.
// - Each time pulse loads the bus value into registers selected during that state; the address and buffer registers only at pulses one and three.
// - A cycle has five time states, each ended by a pulse starting the next.
// - Transitions follow the leading edge of a pulse; pulse width never stretches cycles.
// - Cycle starts at pulse one, runs state two to pulse five, then state one.
// - The first cycle starts when the console timing chain completes.
// - Long operations repeat state five through the delayed pulse until done.
// - Pulse one starts memory when memory access is enabled outside console execute or a peripheral transfer is pending.
// - Pause release checks the repeat flag; if set the delayed pulse reruns pulse five.
// - A sample pulse in state five checks whether a peripheral is ready.
// - A ready peripheral gets memory prepared for its transfer next cycle.
// - Pulse one clears old commands and state three decides direct or indirect addressing.
// - Nine major state cycle sequences are supported.
// - The memory address register loads only at pulse one.
// - The memory buffer register normally loads at pulse three.
// - Memory cycle starts at pulse one when access needed outside console execute, or for a pending peripheral transfer.
// - Memory strobe marks read data, triggers pulse two and captures the word.
// - The register bus is usable in every state, up to five loads per cycle.
// - Active registers take new values from the register bus, except the buffer capturing the memory word.
// - Carry ripples stage to stage with an external carry insert at bit zero.
`default_nettype none
module ctss_sequencer
    import ctss_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        console_done_i,
    input  wire logic        run_i,
    input  wire logic        mem_enable_i,
    input  wire logic        console_execute_i,
    input  wire logic        mem_strobe_i,
    input  wire logic [11:0] mem_data_i,
    input  wire logic        periph_ready_i,
    input  wire logic        long_op_start_i,
    input  wire logic        long_op_done_i,
    input  wire logic        indirect_bit_i,
    input  wire logic [3:0]  next_major_i,
    input  wire logic [11:0] operand_a_i,
    input  wire logic [11:0] operand_b_i,
    input  wire logic        carry_insert_i,
    input  wire logic [4:0]  load_select_i,
    output logic             time_state_one_o,
    output logic             time_state_two_o,
    output logic             time_state_three_o,
    output logic             time_state_four_o,
    output logic             time_state_five_o,
    output logic             time_pulse_o,
    output logic [2:0]       pulse_number_o,
    output logic             mem_start_o,
    output logic             peripheral_memory_setup_o,
    output logic             state5_repeat_flag_o,
    output logic             indirect_o,
    output logic [3:0]       major_state_o,
    output logic             carry_o,
    output logic [11:0]      accumulator_o,
    output logic [11:0]      program_counter_o,
    output logic [11:0]      memory_address_reg_o,
    output logic [11:0]      memory_buffer_reg_o,
    output logic [11:0]      instruction_reg_o
);
    ctss_state_t state_reg;
    ctss_state_t state_next;
    logic [6:0]  cnt_reg;
    logic        repeat_reg;
    logic        periph_pend_reg;
    logic        started_reg;
    logic [11:0] bus_sum;
    logic        bus_carry;

    // Datapath: operands pass through the adders onto the register bus in every state.
    ctss_adder u_adder (
        .a_i            (operand_a_i),
        .b_i            (operand_b_i),
        .carry_insert_i (carry_insert_i),
        .sum_o          (bus_sum),
        .carry_o        (bus_carry)
    );

    function automatic logic [2:0] pulse_of(input ctss_state_t s);
        case (s)
            CTSS_ONE:   pulse_of = 3'h1;
            CTSS_TWO:   pulse_of = 3'h2;
            CTSS_THREE: pulse_of = 3'h3;
            CTSS_FOUR:  pulse_of = 3'h4;
            CTSS_FIVE:  pulse_of = 3'h5;
            default:    pulse_of = 3'h0;
        endcase
    endfunction : pulse_of

    // A state ends after its minimum length; state two instead waits for the memory strobe when a memory cycle was started.
    wire timed_out   = (cnt_reg >= STATE_LAST);
    wire in_two      = (state_reg == CTSS_TWO);
    wire in_five     = (state_reg == CTSS_FIVE);
    wire mem_wait    = in_two & started_reg;
    wire pulse_fire  = (state_reg != CTSS_IDLE) &&
                       (mem_wait ? mem_strobe_i : timed_out);
    wire [2:0] pnum  = pulse_of(state_reg);
    wire pulse_one   = pulse_fire & (pnum == 3'h1);
    wire pulse_three = pulse_fire & (pnum == 3'h3);
    wire fifth_event = pulse_fire & in_five;
    // Long operations reuse state five: the delayed pulse replaces pulse five while repeating.
    wire delayed_fifth_pulse = fifth_event & repeat_reg & ~long_op_done_i;
    wire time_pulse_five     = fifth_event & ~delayed_fifth_pulse;
    wire peripheral_sample_pulse = in_five & (cnt_reg == STATE_CNT_RESET);
    wire need_mem    = mem_enable_i & ~console_execute_i;

    always_comb begin
        state_next = state_reg;
        if (!run_i) begin
            state_next = CTSS_IDLE;
        end else begin
            case (state_reg)
                CTSS_IDLE:  if (console_done_i) state_next = CTSS_ONE;
                CTSS_ONE:   if (pulse_fire) state_next = CTSS_TWO;
                CTSS_TWO:   if (pulse_fire) state_next = CTSS_THREE;
                CTSS_THREE: if (pulse_fire) state_next = CTSS_FOUR;
                CTSS_FOUR:  if (pulse_fire) state_next = CTSS_FIVE;
                CTSS_FIVE:  if (time_pulse_five) state_next = CTSS_ONE;
                default:   state_next = CTSS_IDLE;
            endcase
        end
    end

    // The pulse is a single-clock marker, so its width never adds to the state length.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= CTSS_IDLE;
            cnt_reg   <= STATE_CNT_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (pulse_fire || state_reg == CTSS_IDLE) ? STATE_CNT_RESET : cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            repeat_reg      <= 1'b0;
            periph_pend_reg <= 1'b0;
            started_reg     <= 1'b0;
        end else begin
            if (long_op_done_i) begin
                repeat_reg <= 1'b0;
            end else if (long_op_start_i && state_reg == CTSS_FOUR) begin
                repeat_reg <= 1'b1;
            end
            // A ready peripheral seen in state five is served in the next cycle's memory access.
            if (peripheral_sample_pulse && periph_ready_i) begin
                periph_pend_reg <= 1'b1;
            end else if (pulse_one) begin
                periph_pend_reg <= 1'b0;
            end
            if (pulse_one) begin
                started_reg <= need_mem | periph_pend_reg;
            end else if (pulse_fire && in_two) begin
                started_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            time_state_one_o          <= 1'b0;
            time_state_two_o          <= 1'b0;
            time_state_three_o        <= 1'b0;
            time_state_four_o         <= 1'b0;
            time_state_five_o         <= 1'b0;
            time_pulse_o              <= 1'b0;
            pulse_number_o            <= 3'h0;
            mem_start_o               <= 1'b0;
            peripheral_memory_setup_o <= 1'b0;
            state5_repeat_flag_o      <= 1'b0;
            indirect_o                <= 1'b0;
            major_state_o             <= MAJOR_FETCH;
            carry_o                   <= 1'b0;
        end else begin
            time_state_one_o          <= (state_next == CTSS_ONE);
            time_state_two_o          <= (state_next == CTSS_TWO);
            time_state_three_o        <= (state_next == CTSS_THREE);
            time_state_four_o         <= (state_next == CTSS_FOUR);
            time_state_five_o         <= (state_next == CTSS_FIVE);
            time_pulse_o              <= pulse_fire;
            pulse_number_o            <= pulse_fire ? pnum : 3'h0;
            mem_start_o               <= pulse_one & (need_mem | periph_pend_reg);
            peripheral_memory_setup_o <= periph_pend_reg;
            state5_repeat_flag_o      <= repeat_reg;
            // Pulse one drops the previous cycle's addressing mode and state three decides the new one.
            if (state_reg == CTSS_THREE) begin
                indirect_o <= indirect_bit_i;
            end else if (pulse_one) begin
                indirect_o <= 1'b0;
            end
            // Out-of-range major state requests fall back to fetch.
            if (time_pulse_five) begin
                major_state_o <= (next_major_i < MAJOR_COUNT) ? next_major_i : MAJOR_FETCH;
            end
            if (pulse_fire) begin
                carry_o <= bus_carry;
            end
        end
    end

    // Active registers: bus loads come at a pulse, gated by the select made in the state; the buffer also takes the memory word at pulse two.
    wire ld_ac = pulse_fire & load_select_i[0];
    wire ld_pc = pulse_fire & load_select_i[1];
    wire ld_addr  = pulse_one & load_select_i[2];
    wire ld_buf   = pulse_three & load_select_i[3];
    wire ld_instr = pulse_fire & load_select_i[4];
    wire cap_mem = pulse_fire & mem_wait;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            accumulator_o        <= WORD_RESET;
            program_counter_o    <= WORD_RESET;
            memory_address_reg_o <= WORD_RESET;
            memory_buffer_reg_o  <= WORD_RESET;
            instruction_reg_o    <= WORD_RESET;
        end else begin
            if (ld_ac) accumulator_o        <= bus_sum;
            if (ld_pc) program_counter_o    <= bus_sum;
            if (ld_addr) memory_address_reg_o <= bus_sum;
            if (ld_buf) begin
                memory_buffer_reg_o <= bus_sum;
            end else if (cap_mem) begin
                memory_buffer_reg_o <= mem_data_i;
            end
            if (ld_instr) instruction_reg_o <= bus_sum;
        end
    end
endmodule : ctss_sequencer
`default_nettype wire

// [ctss_pkg.sv]
// Package holding the timing constants, state codes and widths of the time state sequencer.
`default_nettype none
package ctss_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 8;
    localparam int unsigned WORD_BITS          = 12;
    localparam int unsigned STATE_MIN_NS       = 250;
    localparam int unsigned STATE_MAX_NS       = 520;
    localparam int unsigned PULSE_NS           = 100;
    localparam int unsigned STATE_MIN_CYC      = (STATE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STATE_MAX_CYC      = STATE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CYC          = PULSE_NS / CLK_PERIOD_NS;
    localparam logic [6:0]  STATE_CYC          = 7'(STATE_MIN_CYC);
    localparam logic [6:0]  STATE_LAST         = 7'(STATE_MIN_CYC - 1);
    localparam logic [6:0]  STATE_CNT_RESET    = 7'h00;
    localparam logic [3:0]  MAJOR_COUNT        = 4'h9;
    localparam logic [3:0]  MAJOR_FETCH        = 4'h0;
    localparam logic [11:0] WORD_RESET         = 12'h000;

    typedef enum logic [5:0] {
        CTSS_IDLE  = 6'h01,
        CTSS_ONE   = 6'h02,
        CTSS_TWO   = 6'h04,
        CTSS_THREE = 6'h08,
        CTSS_FOUR  = 6'h10,
        CTSS_FIVE  = 6'h20
    } ctss_state_t;
endpackage : ctss_pkg
`default_nettype wire

// [ctss_adder_stage.sv]
// One-bit adder stage of the register bus arithmetic unit.
`default_nettype none
module ctss_adder_stage
(
    input  wire logic a_i,
    input  wire logic b_i,
    input  wire logic carry_i,
    output logic      sum_o,
    output logic      carry_o
);
    // Both operands and carry in set give sum one and carry out one.
    assign sum_o   = a_i ^ b_i ^ carry_i;
    assign carry_o = (a_i & b_i) | (carry_i & (a_i | b_i));
endmodule : ctss_adder_stage
`default_nettype wire

// [ctss_adder.sv]
// Twelve-stage ripple adder built from one-bit stages.
`default_nettype none
module ctss_adder
    import ctss_pkg::*;
(
    input  wire logic [11:0] a_i,
    input  wire logic [11:0] b_i,
    input  wire logic        carry_insert_i,
    output logic      [11:0] sum_o,
    output logic             carry_o
);
    logic [12:0] chain;
    assign chain[0] = carry_insert_i;
    for (genvar i = 0; i < WORD_BITS; i++) begin : g_stage
        ctss_adder_stage u_stage (
            .a_i     (a_i[i]),
            .b_i     (b_i[i]),
            .carry_i (chain[i]),
            .sum_o   (sum_o[i]),
            .carry_o (chain[i+1])
        );
    end
    assign carry_o = chain[12];
endmodule : ctss_adder
`default_nettype wire

// [ctss_properties.sv]
// Checker of the port timing of the time state sequencer.
`default_nettype none
module ctss_checker
    import ctss_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic        console_done_i,
    input wire logic        mem_enable_i,
    input wire logic        console_execute_i,
    input wire logic        time_state_one_o,
    input wire logic        time_state_two_o,
    input wire logic        time_state_three_o,
    input wire logic        time_state_four_o,
    input wire logic        time_state_five_o,
    input wire logic        time_pulse_o,
    input wire logic [2:0]  pulse_number_o,
    input wire logic        mem_start_o,
    input wire logic        peripheral_memory_setup_o,
    input wire logic [11:0] memory_address_reg_o,
    input wire logic [11:0] memory_buffer_reg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire [4:0] states = {time_state_five_o, time_state_four_o, time_state_three_o, time_state_two_o, time_state_one_o};
    wire       first_pulse = time_pulse_o && pulse_number_o == 3'h1;
    wire       mid_pulse   = time_pulse_o && (pulse_number_o == 3'h2 || pulse_number_o == 3'h3);
    logic [6:0] gap_reg;
    logic       armed_reg;
    // Pulse two is left out of the gap check because it may wait any time for the strobe.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_reg   <= 7'h00;
            armed_reg <= 1'b0;
        end else begin
            gap_reg   <= time_pulse_o ? 7'h00 : gap_reg + 7'h01;
            armed_reg <= (|states) && (armed_reg || time_pulse_o);
        end
    end
    a_state_onehot: assert property ($onehot0(states))
        else $error("time states not one-hot");
    a_pulse_single: assert property (time_pulse_o |=> !time_pulse_o)
        else $error("time pulse longer than one cycle");
    a_pulse_number: assert property ((pulse_number_o != 3'h0) == time_pulse_o && pulse_number_o <= 3'h5)
        else $error("pulse number out of step with the pulse");
    a_state_length: assert property (time_pulse_o && armed_reg && pulse_number_o != 3'h2 |-> gap_reg == STATE_LAST)
        else $error("time state length wrong");
    a_state_order: assert property (time_pulse_o |-> (pulse_number_o == 3'h5) ?
        (states == 5'h01 || states == 5'h10) : (states == (5'h01 << pulse_number_o))) else $error("state order wrong");
    a_mem_start_place: assert property (mem_start_o |-> first_pulse && !$past(console_execute_i)
        && $past(mem_enable_i || peripheral_memory_setup_o)) else $error("memory start out of place");
    a_addr_load_place: assert property ($changed(memory_address_reg_o) |-> first_pulse)
        else $error("address register changed away from pulse one");
    a_buf_load_place: assert property ($changed(memory_buffer_reg_o) |-> mid_pulse)
        else $error("buffer register changed away from pulses two and three");
    a_idle_holds: assert property (states == 5'h00 && !console_done_i && !$past(console_done_i) |=> states == 5'h00)
        else $error("cycle started without console completion");
endmodule : ctss_checker
bind ctss_sequencer ctss_checker ctss_checker_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .console_done_i(console_done_i),
    .mem_enable_i(mem_enable_i), .console_execute_i(console_execute_i),
    .time_state_one_o(time_state_one_o), .time_state_two_o(time_state_two_o),
    .time_state_three_o(time_state_three_o), .time_state_four_o(time_state_four_o),
    .time_state_five_o(time_state_five_o), .time_pulse_o(time_pulse_o), .pulse_number_o(pulse_number_o),
    .mem_start_o(mem_start_o), .peripheral_memory_setup_o(peripheral_memory_setup_o),
    .memory_address_reg_o(memory_address_reg_o), .memory_buffer_reg_o(memory_buffer_reg_o));
`default_nettype wire

// [ctss_mem_model.sv]
// Core memory control model answering each memory start with a strobe and a word.
`default_nettype none
module ctss_mem_model #(
    parameter logic [11:0] READ_WORD = 12'h5a3
) (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        mem_start_i,
    input  wire logic [7:0]  latency_i,
    output logic             strobe_o,
    output logic      [11:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_reg;
    logic       busy_reg;
    // Outside the strobe the data lines toggle, so a stale word is never taken as fresh.
    always @(negedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_reg <= 1'b0;
            strobe_o <= 1'b0;
            data_o   <= ~READ_WORD;
        end else begin
            strobe_o <= 1'b0;
            data_o   <= ~data_o;
            if (mem_start_i) begin
                busy_reg <= 1'b1;
                wait_reg <= latency_i;
            end else if (busy_reg && wait_reg == 8'h00) begin
                busy_reg <= 1'b0;
                strobe_o <= 1'b1;
                data_o   <= READ_WORD;
            end else if (busy_reg) begin
                wait_reg <= wait_reg - 8'h01;
            end
        end
    end
endmodule : ctss_mem_model
`default_nettype wire

// [tb_ctss_sequencer.sv]
// Self-checking testbench of the time state sequencer.
`default_nettype none
module tb_ctss_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] MEM_WORD = 12'h5a3;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, console_done_i = 1'b0, run_i = 1'b1, mem_enable_i = 1'b1;
    logic console_execute_i = 1'b0, periph_ready_i = 1'b0, long_op_start_i = 1'b0, long_op_done_i = 1'b0;
    logic indirect_bit_i = 1'b0, carry_insert_i = 1'b1, mem_strobe_i, time_state_one_o, time_state_two_o;
    logic time_state_three_o, time_state_four_o, time_state_five_o, time_pulse_o, mem_start_o, carry_o;
    logic peripheral_memory_setup_o, state5_repeat_flag_o, indirect_o;
    logic [2:0] pulse_number_o;
    logic [3:0] next_major_i = 4'h8, major_state_o;
    logic [4:0] load_select_i = 5'h17;
    logic [7:0] mem_latency = 8'h14;
    logic [11:0] operand_a_i = 12'hfff, operand_b_i = 12'h001, mem_data_i, accumulator_o, program_counter_o;
    logic [11:0] memory_address_reg_o, memory_buffer_reg_o, instruction_reg_o;
    int miscompares = 0;
    int comparisons = 0;
    always #4 core_clk_i = ~core_clk_i;
    ctss_sequencer ctss_sequencer_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .console_done_i(console_done_i), .run_i(run_i), .mem_enable_i(mem_enable_i),
        .console_execute_i(console_execute_i), .mem_strobe_i(mem_strobe_i), .mem_data_i(mem_data_i),
        .periph_ready_i(periph_ready_i), .long_op_start_i(long_op_start_i), .long_op_done_i(long_op_done_i),
        .indirect_bit_i(indirect_bit_i), .next_major_i(next_major_i), .operand_a_i(operand_a_i),
        .operand_b_i(operand_b_i), .carry_insert_i(carry_insert_i), .load_select_i(load_select_i),
        .time_state_one_o(time_state_one_o), .time_state_two_o(time_state_two_o),
        .time_state_three_o(time_state_three_o), .time_state_four_o(time_state_four_o),
        .time_state_five_o(time_state_five_o), .time_pulse_o(time_pulse_o), .pulse_number_o(pulse_number_o),
        .mem_start_o(mem_start_o), .peripheral_memory_setup_o(peripheral_memory_setup_o),
        .state5_repeat_flag_o(state5_repeat_flag_o), .indirect_o(indirect_o), .major_state_o(major_state_o),
        .carry_o(carry_o), .accumulator_o(accumulator_o), .program_counter_o(program_counter_o),
        .memory_address_reg_o(memory_address_reg_o), .memory_buffer_reg_o(memory_buffer_reg_o),
        .instruction_reg_o(instruction_reg_o));
    ctss_mem_model #(.READ_WORD(MEM_WORD)) ctss_mem_model_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .mem_start_i(mem_start_o), .latency_i(mem_latency), .strobe_o(mem_strobe_i), .data_o(mem_data_i));
    task automatic tally_and_finish;
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask : chk
    // Waits at falling edges, where outputs are settled, for the given numbered pulse.
    task automatic wait_pulse(input logic [2:0] num, input int settle);
        int n;
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
        end while (!(time_pulse_o === 1'b1 && pulse_number_o === num) && n < 400);
        if (n >= 400) begin
            miscompares++;
            $display("Error at %0t ns: no pulse %0d", $time, num);
            tally_and_finish();
        end
        repeat (settle) @(negedge core_clk_i);
    endtask : wait_pulse
    task automatic t_idle_start;
        repeat (40) @(negedge core_clk_i);
        chk(time_state_one_o === 1'b0 && time_pulse_o === 1'b0, "left idle unasked");
        console_done_i = 1'b1;
        @(negedge core_clk_i);
        console_done_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk(time_state_one_o === 1'b1, "no state one after console start");
        $display("Test idle_start done");
    endtask : t_idle_start
    task automatic t_bus_loads;
        wait_pulse(3'h1, 0);
        chk(mem_start_o === 1'b1, "no memory start");
        repeat (2) @(negedge core_clk_i);
        chk(memory_address_reg_o === 12'h001 && accumulator_o === 12'h001, "pulse one loads");
        chk(program_counter_o === 12'h001 && instruction_reg_o === 12'h001, "pulse one bus loads");
        chk(carry_o === 1'b1, "carry out lost");
        operand_a_i = 12'h123;
        carry_insert_i = 1'b0;
        wait_pulse(3'h2, 2);
        chk(memory_buffer_reg_o === MEM_WORD, "read word not captured");
        chk(accumulator_o === 12'h124 && memory_address_reg_o === 12'h001, "pulse two loads");
        chk(carry_o === 1'b0, "false carry");
        chk(program_counter_o === 12'h124 && instruction_reg_o === 12'h124, "pulse two bus loads");
        load_select_i = 5'h0c;
        wait_pulse(3'h3, 2);
        chk(memory_buffer_reg_o === 12'h124 && memory_address_reg_o === 12'h001, "pulse three loads");
        operand_a_i = 12'h3ff;
        wait_pulse(3'h4, 2);
        chk(memory_buffer_reg_o === 12'h124 && memory_address_reg_o === 12'h001, "pulse four loads");
        chk(accumulator_o === 12'h124 && instruction_reg_o === 12'h124, "unselected register loaded");
        load_select_i = 5'h17;
        $display("Test bus_loads done");
    endtask : t_bus_loads
    task automatic t_no_mem_start;
        for (int k = 0; k < 2; k++) begin
            mem_enable_i = (k == 0);
            console_execute_i = (k == 0);
            wait_pulse(3'h1, 0);
            chk(mem_start_o === 1'b0, "memory started when not allowed");
        end
        mem_enable_i = 1'b1;
        console_execute_i = 1'b0;
        mem_latency = 8'h02;
        $display("Test no_mem_start done");
    endtask : t_no_mem_start
    task automatic t_indirect;
        indirect_bit_i = 1'b1;
        wait_pulse(3'h3, 2);
        chk(indirect_o === 1'b1, "indirect not taken");
        indirect_bit_i = 1'b0;
        wait_pulse(3'h1, 2);
        chk(indirect_o === 1'b0, "indirect not cleared");
        $display("Test indirect done");
    endtask : t_indirect
    task automatic t_repeat;
        long_op_start_i = 1'b1;
        wait_pulse(3'h4, 2);
        long_op_start_i = 1'b0;
        chk(state5_repeat_flag_o === 1'b1, "repeat flag not set");
        wait_pulse(3'h5, 2);
        chk(time_state_five_o === 1'b1, "state five not repeated");
        long_op_done_i = 1'b1;
        wait_pulse(3'h5, 2);
        long_op_done_i = 1'b0;
        chk(time_state_one_o === 1'b1 && state5_repeat_flag_o === 1'b0, "repeat not ended");
        chk(major_state_o === 4'h8, "major state not taken");
        next_major_i = 4'h9;
        wait_pulse(3'h5, 2);
        chk(major_state_o === 4'h0, "bad major state kept");
        $display("Test repeat done");
    endtask : t_repeat
    task automatic t_periph;
        mem_enable_i = 1'b0;
        periph_ready_i = 1'b1;
        wait_pulse(3'h5, 2);
        periph_ready_i = 1'b0;
        chk(peripheral_memory_setup_o === 1'b1, "ready peripheral missed");
        wait_pulse(3'h1, 0);
        chk(mem_start_o === 1'b1, "no memory start for peripheral");
        mem_enable_i = 1'b1;
        $display("Test periph done");
    endtask : t_periph
    initial begin
        repeat (3) @(negedge core_clk_i);
        resetn_i = 1'b1;
        t_idle_start();
        t_bus_loads();
        t_no_mem_start();
        t_indirect();
        t_repeat();
        t_periph();
        tally_and_finish();
    end
endmodule : tb_ctss_sequencer
`default_nettype wire
